// ### rtl/dmb_bank_addr.sv
// Purpose: data memory address formation, bank pointer and ram
// Assumes: core drives one op per clock, same clock domain
// Notes:   read data and done appear one clock after the op
`include "dmb_cfg.svh"

// What this block does
// - data memory is sixteen banks of 256 bytes, 12-bit addresses.
// - banked address is bank pointer on top, operand byte below.
// - only bank pointer bits 3:0 exist; upper bits read zero.
// - load-bank-literal op loads the bank pointer directly.
// - unimplemented banks ignore writes and read as zero.
// - status flags update as if unimplemented accesses succeeded.
// - full-address move uses 12-bit addresses, ignores bank pointer.
// - access window 00h-5Fh is bank 0, 60h-FFh is bank 15 top.
// - access bit 1 uses bank pointer; 0 uses access map.
// - access-map accesses complete in one cycle; a write at E0h (FE0h) updates the bank pointer.
// - extended set enable alters the access bank mapping.
// - ram is never cleared by any reset.
// - ram starts at 000h and grows up toward the registers.
// - special registers sit at the top of data memory.
// - unused special register locations read as zero.
// - EB0h-F5Fh are outside the access window.
module dmb_bank_addr
    import dmb_pkg::*;
(
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire dmb_op_t                op_i,
    input  wire logic [`DMB_OFFS_W-1:0] opnd_i,
    input  wire logic                   access_sel_i,
    input  wire logic [7:0]             wr_data_i,
    input  wire logic [7:0]             literal_i,
    input  wire logic [`DMB_ADDR_W-1:0] move_src_i,
    input  wire logic [`DMB_ADDR_W-1:0] move_dst_i,
    input  wire logic                   extended_set_enable_i,
    input  wire logic [`DMB_ADDR_W-1:0] index_base_i,
    output logic      [7:0]             rd_data_o,
    output logic      [`DMB_ADDR_W-1:0] addr_o,
    output logic                        done_o,
    output logic                        zero_o,
    output logic      [7:0]             bank_pointer_o
);
    logic [7:0]             ram [0:`DMB_GPR_DEPTH-1];
    logic [`DMB_BANK_W-1:0] bank_pointer;

    // single place where a 12-bit address is turned into read data
    function automatic logic is_gpr(input logic [`DMB_ADDR_W-1:0] a);
        is_gpr = (a <= `DMB_GPR_LAST);
    endfunction

    function automatic logic bank_ok(input logic [`DMB_ADDR_W-1:0] a);
        logic [15:0] impl;
        impl = `DMB_BANK_IMPL;
        bank_ok = impl[a[11:8]];
    endfunction

    function automatic logic [7:0] peek(input logic [`DMB_ADDR_W-1:0] a,
                                        input logic [`DMB_BANK_W-1:0] bp);
        peek = 8'h00;
        if (!bank_ok(a))
            peek = 8'h00;
        else if (is_gpr(a))
            peek = ram[a];
        else if (a == `DMB_BANK_PTR_ADR)
            peek = {4'h0, bp};
        else
            peek = 8'h00;
    endfunction

    wire logic acc_low = (opnd_i <= `DMB_ACC_LOW_LAST);
    wire logic [`DMB_ADDR_W-1:0] acc_std =
        acc_low ? {`DMB_ACC_LO_BANK, opnd_i} : {`DMB_ACC_HI_BANK, opnd_i};
    wire logic [`DMB_ADDR_W-1:0] acc_ext =
        index_base_i + {4'h0, opnd_i};
    wire logic [`DMB_ADDR_W-1:0] acc_addr =
        (extended_set_enable_i && acc_low) ? acc_ext : acc_std;
    wire logic [`DMB_ADDR_W-1:0] bank_addr = {bank_pointer, opnd_i};
    wire logic [`DMB_ADDR_W-1:0] op_addr =
        access_sel_i ? bank_addr : acc_addr;
    wire logic [`DMB_ADDR_W-1:0] rd_addr =
        (op_i == DMB_OP_MOVE) ? move_src_i : op_addr;
    wire logic [`DMB_ADDR_W-1:0] wr_addr =
        (op_i == DMB_OP_MOVE) ? move_dst_i : op_addr;
    wire logic [7:0] rd_value = peek(rd_addr, bank_pointer);
    wire logic is_wr = (op_i == DMB_OP_WRITE) || (op_i == DMB_OP_MOVE);
    wire logic [7:0] wr_value =
        (op_i == DMB_OP_MOVE) ? rd_value : wr_data_i;
    wire logic wr_ram = is_wr && bank_ok(wr_addr) && is_gpr(wr_addr);
    wire logic wr_bp  = is_wr && bank_ok(wr_addr)
                        && (wr_addr == `DMB_BANK_PTR_ADR);
    wire logic [`DMB_ADDR_W-1:0] next_addr =
        (op_i == DMB_OP_MOVE) ? move_dst_i : rd_addr;
    // flag follows the byte that moved, read value on reads
    wire logic [7:0] flag_value =
        (op_i == DMB_OP_WRITE) ? wr_data_i : rd_value;

    always_ff @(posedge mclk_i)
    begin
        if (wr_ram)
            ram[wr_addr] <= wr_value;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bank_pointer <= `DMB_BANK_PTR_RST;
        else if (op_i == DMB_OP_LOAD_BANK)
            bank_pointer <= literal_i[`DMB_BANK_W-1:0];
        else if (wr_bp)
            bank_pointer <= wr_value[`DMB_BANK_W-1:0];
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_o <= 8'h00;
            addr_o    <= '0;
            done_o    <= 1'b0;
            zero_o    <= 1'b0;
        end
        else
        begin
            rd_data_o <= (op_i == DMB_OP_NONE) ? rd_data_o : rd_value;
            addr_o    <= (op_i == DMB_OP_NONE) ? addr_o : next_addr;
            done_o    <= (op_i != DMB_OP_NONE);
            zero_o    <= (op_i == DMB_OP_NONE) ? zero_o
                                               : (flag_value == 8'h00);
        end
    end

    // mirror keeps output flop-driven and in step with the register
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bank_pointer_o <= 8'h00;
        else if (op_i == DMB_OP_LOAD_BANK)
            bank_pointer_o <= {4'h0, literal_i[`DMB_BANK_W-1:0]};
        else if (wr_bp)
            bank_pointer_o <= {4'h0, wr_value[`DMB_BANK_W-1:0]};
    end
endmodule

// ### inc/dmb_cfg.svh
// Purpose: constants for data memory bank addressing
// Assumes: included by package and design files
// Notes:   addresses are 12-bit data addresses
`ifndef DMB_CFG_SVH
`define DMB_CFG_SVH
`define DMB_ADDR_W       12
`define DMB_BANK_W       4
`define DMB_OFFS_W       8
`define DMB_GPR_FIRST    12'h000
`define DMB_GPR_LAST     12'heaf
`define DMB_GPR_DEPTH    3760
`define DMB_SFR_FIRST    12'heb0
`define DMB_SFR_CORE     12'hf40
`define DMB_BANK_PTR_ADR 12'hfe0
`define DMB_BANK_PTR_RST 4'h0
`define DMB_BANK_IMPL    16'hffff
`define DMB_ACC_LOW_LAST 8'h5f
`define DMB_ACC_HI_BANK  4'hf
`define DMB_ACC_LO_BANK  4'h0
`endif

// ### inc/dmb_pkg.sv
// Purpose: types for data memory bank addressing
// Assumes: dmb_cfg.svh on the include path
// Notes:   op codes are driven by the core decode stage
package dmb_pkg;
    typedef enum logic [2:0]
    {
        DMB_OP_NONE      = 3'b000,
        DMB_OP_READ      = 3'b001,
        DMB_OP_WRITE     = 3'b010,
        DMB_OP_LOAD_BANK = 3'b011,
        DMB_OP_MOVE      = 3'b100
    } dmb_op_t;
endpackage

// ### sim/dmb_bank_addr_asserts.sv
// Purpose: port checks for data memory bank addressing
// Assumes: one clock domain, async active-low reset
// Notes:   extended map checked below 60h only
module dmb_bank_addr_asserts
    import dmb_pkg::*;
(
    input wire logic        mclk_i, rst_n_i, access_sel_i, done_o, zero_o,
    input wire logic        extended_set_enable_i,
    input wire dmb_op_t     op_i,
    input wire logic [7:0]  opnd_i, wr_data_i, literal_i, rd_data_o,
    input wire logic [7:0]  bank_pointer_o,
    input wire logic [11:0] move_src_i, move_dst_i, index_base_i, addr_o
);
    wire rw = op_i == DMB_OP_READ || op_i == DMB_OP_WRITE;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    chk_done_pulse: assert property (op_i != DMB_OP_NONE |=> done_o)
        else $error("no done after op");
    chk_done_idle: assert property (op_i == DMB_OP_NONE |=> !done_o)
        else $error("done without op");
    chk_bank_upper: assert property (bank_pointer_o[7:4] == 4'h0)
        else $error("bank upper bits set");
    chk_bank_load: assert property (op_i == DMB_OP_LOAD_BANK
        |=> bank_pointer_o == ($past(literal_i) & 8'h0f)) else $error("load");
    chk_banked_addr: assert property (rw && access_sel_i |=>
        {4'h0, addr_o[11:8]} == $past(bank_pointer_o)
        && addr_o[7:0] == $past(opnd_i)) else $error("banked addr");
    chk_access_map: assert property (rw && !access_sel_i
        && !extended_set_enable_i |=> addr_o == {($past(opnd_i) > 8'h5f
        ? 4'hf : 4'h0), $past(opnd_i)}) else $error("access addr");
    chk_ext_map: assert property (rw && !access_sel_i
        && extended_set_enable_i && opnd_i < 8'h60
        |=> addr_o == $past(index_base_i) + $past(opnd_i))
        else $error("extended addr");
    chk_move_addr: assert property (op_i == DMB_OP_MOVE
        |=> addr_o == $past(move_dst_i)) else $error("move addr");
    chk_zero_write: assert property (op_i == DMB_OP_WRITE
        |=> zero_o == ($past(wr_data_i) == 8'h00)) else $error("zero flag");
    chk_zero_read: assert property (op_i == DMB_OP_READ
        |=> zero_o == (rd_data_o == 8'h00)) else $error("read zero flag");
endmodule
bind dmb_bank_addr dmb_bank_addr_asserts u_chk (.mclk_i, .rst_n_i, .op_i,
    .access_sel_i, .done_o, .zero_o, .extended_set_enable_i, .opnd_i,
    .wr_data_i, .literal_i, .rd_data_o, .bank_pointer_o, .move_src_i,
    .move_dst_i, .index_base_i, .addr_o);

// ### sim/dmb_core_model.sv
// Purpose: core decode stage model, one op per call
// Assumes: called only after reset release
// Notes:   operands invert after the op so stale values never pass
module dmb_core_model
    import dmb_pkg::*;
(
    input  wire logic   mclk_i,
    output dmb_op_t     op_o,
    output logic [7:0]  opnd_o,
    output logic [7:0]  dat_o,
    output logic        acc_o,
    output logic [11:0] src_o,
    output logic [11:0] dst_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial op_o = DMB_OP_NONE;
    initial {opnd_o, dat_o, acc_o, src_o, dst_o} = '0;
    task run(dmb_op_t o, logic [7:0] n, d, logic a, logic [11:0] s, t);
        @(posedge mclk_i);
        op_o <= o;
        {opnd_o, dat_o, acc_o, src_o, dst_o} <= {n, d, a, s, t};
        @(posedge mclk_i);
        op_o <= DMB_OP_NONE;
        {opnd_o, dat_o, acc_o, src_o, dst_o} <= ~{n, d, a, s, t};
    endtask
endmodule

// ### sim/dmb_bank_addr_tb.sv
// Purpose: directed tests of bank addressing through the op port
// Assumes: ram powers up unknown, so reads follow writes
// Notes:   outputs sampled 1ns after the answering edge
module dmb_bank_addr_tb
    import dmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, extended_set_enable_i = 1'b0;
    logic [11:0] index_base_i = 12'h200, move_src_i, move_dst_i, addr_o;
    logic [7:0] opnd_i, wr_data_i, rd_data_o, bank_pointer_o;
    logic access_sel_i, done_o, zero_o;
    dmb_op_t op_i;
    int failures = 0, tests_run = 0;
    always #50 mclk_i = ~mclk_i;
    dmb_core_model u_core (.mclk_i, .op_o(op_i), .opnd_o(opnd_i),
        .dat_o(wr_data_i), .acc_o(access_sel_i), .src_o(move_src_i),
        .dst_o(move_dst_i));
    dmb_bank_addr u_dut (.mclk_i, .rst_n_i, .op_i, .opnd_i, .access_sel_i,
        .wr_data_i, .literal_i(wr_data_i), .move_src_i, .move_dst_i,
        .extended_set_enable_i, .index_base_i, .rd_data_o, .addr_o,
        .done_o, .zero_o, .bank_pointer_o);
    task ck(string n, logic [11:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task go(dmb_op_t o, logic [7:0] n, d, logic a,
            logic [11:0] s = 12'h000, t = 12'h000);
        u_core.run(o, n, d, a, s, t);
        #1;
        ck("done", 12'h001, {11'h0, done_o});
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        wrap_up;
    end
    initial
    begin
        repeat (20) @(posedge mclk_i);
        ck("bank", 12'h000, bank_pointer_o);
        rst_n_i <= 1'b1;
        go(DMB_OP_LOAD_BANK, 8'h00, 8'hf7, 1'b0);
        ck("bank", 12'h007, bank_pointer_o);
        go(DMB_OP_WRITE, 8'h34, 8'ha5, 1'b1);
        ck("addr", 12'h734, addr_o);
        go(DMB_OP_READ, 8'h34, 8'h00, 1'b1);
        ck("data", 12'h0a5, rd_data_o);
        ck("zero", 12'h000, {11'h0, zero_o});
        go(DMB_OP_WRITE, 8'h5f, 8'h00, 1'b0);
        ck("zero", 12'h001, {11'h0, zero_o});
        go(DMB_OP_MOVE, 8'h00, 8'h00, 1'b1, 12'h734, 12'h123);
        ck("addr", 12'h123, addr_o);
        go(DMB_OP_LOAD_BANK, 8'h00, 8'h01, 1'b0);
        go(DMB_OP_READ, 8'h23, 8'h00, 1'b1);
        ck("data", 12'h0a5, rd_data_o);
        go(DMB_OP_READ, 8'he0, 8'h00, 1'b0);
        ck("data", 12'h001, rd_data_o);
        go(DMB_OP_WRITE, 8'he0, 8'hff, 1'b0);
        ck("bank", 12'h00f, bank_pointer_o);
        go(DMB_OP_MOVE, 8'h00, 8'h00, 1'b0, 12'hf00, 12'h010);
        go(DMB_OP_READ, 8'h10, 8'h00, 1'b0);
        ck("data", 12'h000, rd_data_o);
        extended_set_enable_i <= 1'b1;
        go(DMB_OP_WRITE, 8'h10, 8'h3c, 1'b0);
        ck("addr", 12'h210, addr_o);
        wrap_up;
    end
endmodule
